/* File: core/exec_pkg.sv */
// Purpose: Constants and types shared by the logic, rotate and branch executor.
// Assumes: Eight-bit data, sixteen-bit addresses, one memory cycle per bus transfer.
// Notes: Opcode values are the encodings of this instruction subset.
package exec_pkg;
   localparam logic [7:0] OP_OR_MEMORY       = 8'hB6;
   localparam logic [7:0] OP_OR_IMMEDIATE    = 8'hF6;
   localparam logic [7:0] OP_CMP_MEMORY      = 8'hBE;
   localparam logic [7:0] OP_CMP_IMMEDIATE   = 8'hFE;
   localparam logic [4:0] OP_CMP_REG_TOP     = 5'h17;
   localparam logic [7:0] OP_ROT_LEFT_CIRC   = 8'h07;
   localparam logic [7:0] OP_ROT_RIGHT_CIRC  = 8'h0F;
   localparam logic [7:0] OP_ROT_LEFT_CARRY  = 8'h17;
   localparam logic [7:0] OP_ROT_RIGHT_CARRY = 8'h1F;
   localparam logic [7:0] OP_INVERT_ACC      = 8'h2F;
   localparam logic [7:0] OP_INVERT_CARRY    = 8'h3F;
   localparam logic [7:0] OP_FORCE_CARRY     = 8'h37;
   localparam logic [7:0] OP_JUMP_ABSOLUTE   = 8'hC3;
   localparam logic [7:0] OP_CALL            = 8'hCD;
   localparam logic [7:0] OP_POP_PC          = 8'hC9;
   localparam logic [2:0] COND_JUMP_LOW      = 3'h2;
   localparam logic [2:0] COND_CALL_LOW      = 3'h4;
   localparam logic [2:0] COND_RET_LOW       = 3'h0;
   localparam logic [1:0] CLASS_TOP          = 2'h3;
   localparam logic [2:0] REG_MEMORY_CODE    = 3'h6;
   localparam int         SIGN_BIT           = 7;
   localparam int         ZERO_BIT           = 6;
   localparam int         HALF_BIT           = 4;
   localparam int         PARITY_BIT         = 2;
   localparam int         CARRY_BIT          = 0;
   localparam logic [7:0] FLAGS_RESET        = 8'h02;
   localparam logic [7:0] ACC_RESET          = 8'h00;
   localparam logic [15:0] PC_RESET          = 16'h0000;
   localparam logic [15:0] SP_RESET          = 16'h0000;
   typedef enum logic [7:0] {
      ST_FETCH    = 8'b0000_0001,
      ST_OPCODE   = 8'b0000_0010,
      ST_OPERAND  = 8'b0000_0100,
      ST_ADDR_LO  = 8'b0000_1000,
      ST_ADDR_HI  = 8'b0001_0000,
      ST_PUSH_HI  = 8'b0010_0000,
      ST_PUSH_LO  = 8'b0100_0000,
      ST_POP      = 8'b1000_0000
   } exec_state_e;
endpackage : exec_pkg

/* File: core/alu_if.sv */
// Purpose: Carries operands and results between executor and flag unit.
// Assumes: Combinational path within one clock.
// Notes: The executor drives requests; the flag unit answers.
`timescale 1ns/1ps
interface alu_if;
   logic [7:0] acc;
   logic [7:0] operand;
   logic [7:0] flags_in;
   logic       is_or;
   logic [7:0] result;
   logic [7:0] flags_out;
   modport exec (output acc, operand, flags_in, is_or, input result, flags_out);
   modport unit (input acc, operand, flags_in, is_or, output result, flags_out);
endinterface : alu_if

/* File: core/flag_unit.sv */
// Purpose: Computes OR results and compare flags.
// Assumes: Operands are stable within the cycle.
// Notes: Compare leaves the result unused by the executor.
`timescale 1ns/1ps
module flag_unit
   import exec_pkg::*;
(
   alu_if.unit bus
);
   function automatic logic even_parity(input logic [7:0] v);
      even_parity = ~(^v);
   endfunction : even_parity

   logic [8:0] diff;
   logic [4:0] half;

   always_comb
   begin
      diff = {1'b0, bus.acc} - {1'b0, bus.operand};
      half = {1'b0, bus.acc[3:0]} - {1'b0, bus.operand[3:0]};
      bus.flags_out = bus.flags_in;
      if (bus.is_or)
      begin
         bus.result = bus.acc | bus.operand;
         bus.flags_out[CARRY_BIT] = 1'b0;
         bus.flags_out[HALF_BIT] = 1'b0;
      end
      else
      begin
         bus.result = diff[7:0];
         bus.flags_out[CARRY_BIT] = diff[8];
         bus.flags_out[HALF_BIT] = ~half[4];
      end
      bus.flags_out[ZERO_BIT] = (bus.result == 8'h00);
      bus.flags_out[SIGN_BIT] = bus.result[7];
      bus.flags_out[PARITY_BIT] = even_parity(bus.result);
   end
endmodule : flag_unit

/* File: core/logic_rotate_branch_exec.sv */
// Purpose: Executes OR, compare, rotate, carry and branch instructions.
// Assumes: Memory answers a read or write with mem_ready; wait states stretch cycles.
// Notes: Compare with register takes the register value on reg_operand.
`timescale 1ns/1ps
module logic_rotate_branch_exec
   import exec_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        run,
   input  wire logic [15:0] memory_pointer_pair,
   input  wire logic [7:0]  reg_operand,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        mem_ready,
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   output logic             mem_read,
   output logic             mem_write,
   output logic [7:0]       accumulator,
   output logic [7:0]       flags,
   output logic [15:0]      program_counter,
   output logic [15:0]      stack_pointer,
   output logic             instr_done
);
   typedef struct packed {
      exec_state_e st;
      logic [7:0]  opcode;
      logic [7:0]  addr_lo;
      logic        pop_hi;
      logic [15:0] mem_addr;
      logic [7:0]  mem_wdata;
      logic        mem_read;
      logic        mem_write;
      logic [7:0]  acc;
      logic [7:0]  flags;
      logic [15:0] pc;
      logic [15:0] sp;
      logic        done;
   } exec_s;

   exec_s q;
   exec_s next_q;
   alu_if alu ();

   flag_unit u_flag_unit (
      .bus (alu.unit)
   );

   function automatic logic cond_true(input logic [2:0] cond_field, input logic [7:0] f);
      case (cond_field)
         3'h0:    cond_true = ~f[ZERO_BIT];
         3'h1:    cond_true = f[ZERO_BIT];
         3'h2:    cond_true = ~f[CARRY_BIT];
         3'h3:    cond_true = f[CARRY_BIT];
         3'h4:    cond_true = ~f[PARITY_BIT];
         3'h5:    cond_true = f[PARITY_BIT];
         3'h6:    cond_true = ~f[SIGN_BIT];
         default: cond_true = f[SIGN_BIT];
      endcase
   endfunction : cond_true

   function automatic logic is_cond(input logic [7:0] op, input logic [2:0] low);
      is_cond = (op[7:6] == CLASS_TOP) && (op[2:0] == low);
   endfunction : is_cond

   logic is_cmp_reg;
   logic is_cmp_mem;
   logic taken;
   logic [15:0] pc_inc;
   logic [15:0] sp_dec;

   always_comb
   begin
      is_cmp_reg = (q.opcode[7:3] == OP_CMP_REG_TOP) && (q.opcode[2:0] != REG_MEMORY_CODE);
      is_cmp_mem = (q.opcode == OP_CMP_MEMORY) || (q.opcode == OP_CMP_IMMEDIATE);
      taken = cond_true(q.opcode[5:3], q.flags);
      pc_inc = q.pc + 16'h0001;
      sp_dec = q.sp - 16'h0001;
      alu.acc = q.acc;
      alu.operand = is_cmp_reg ? reg_operand : mem_rdata;
      alu.flags_in = q.flags;
      alu.is_or = (q.opcode == OP_OR_MEMORY) || (q.opcode == OP_OR_IMMEDIATE);
   end

   always_comb
   begin
      next_q = q;
      next_q.done = 1'b0;
      case (q.st)
         ST_FETCH:
         begin
            if (run)
            begin
               next_q.mem_addr = q.pc;
               next_q.mem_read = 1'b1;
               next_q.st = ST_OPCODE;
            end
         end
         ST_OPCODE:
         begin
            if (mem_ready)
            begin
               next_q.mem_read = 1'b0;
               next_q.opcode = mem_rdata;
               next_q.pc = pc_inc;
               next_q.st = ST_FETCH;
               next_q.done = 1'b1;
               case (mem_rdata)
                  OP_OR_MEMORY, OP_CMP_MEMORY:
                  begin
                     next_q.mem_addr = memory_pointer_pair;
                     next_q.mem_read = 1'b1;
                     next_q.st = ST_OPERAND;
                     next_q.done = 1'b0;
                  end
                  OP_OR_IMMEDIATE, OP_CMP_IMMEDIATE:
                  begin
                     next_q.mem_addr = pc_inc;
                     next_q.mem_read = 1'b1;
                     next_q.pc = pc_inc + 16'h0001;
                     next_q.st = ST_OPERAND;
                     next_q.done = 1'b0;
                  end
                  OP_ROT_LEFT_CIRC:
                  begin
                     next_q.acc = {q.acc[6:0], q.acc[7]};
                     next_q.flags[CARRY_BIT] = q.acc[7];
                  end
                  OP_ROT_RIGHT_CIRC:
                  begin
                     next_q.acc = {q.acc[0], q.acc[7:1]};
                     next_q.flags[CARRY_BIT] = q.acc[0];
                  end
                  OP_ROT_LEFT_CARRY:
                  begin
                     next_q.acc = {q.acc[6:0], q.flags[CARRY_BIT]};
                     next_q.flags[CARRY_BIT] = q.acc[7];
                  end
                  OP_ROT_RIGHT_CARRY:
                  begin
                     next_q.acc = {q.flags[CARRY_BIT], q.acc[7:1]};
                     next_q.flags[CARRY_BIT] = q.acc[0];
                  end
                  OP_INVERT_ACC:   next_q.acc = ~q.acc;
                  OP_INVERT_CARRY: next_q.flags[CARRY_BIT] = ~q.flags[CARRY_BIT];
                  OP_FORCE_CARRY:  next_q.flags[CARRY_BIT] = 1'b1;
                  default:
                  begin
                     next_q.done = 1'b0;
                     next_q.st = ST_OPCODE;
                  end
               endcase
               if (next_q.st == ST_OPCODE)
               begin
                  next_q.st = ST_FETCH;
                  next_q.done = 1'b1;
                  if (mem_rdata[7:3] == OP_CMP_REG_TOP)
                  begin
                     next_q.st = ST_OPERAND;
                     next_q.done = 1'b0;
                  end
                  else if (mem_rdata == OP_JUMP_ABSOLUTE || mem_rdata == OP_CALL
                        || is_cond(mem_rdata, COND_JUMP_LOW)
                        || is_cond(mem_rdata, COND_CALL_LOW))
                  begin
                     next_q.mem_addr = pc_inc;
                     next_q.mem_read = 1'b1;
                     next_q.st = ST_ADDR_LO;
                     next_q.done = 1'b0;
                  end
                  else if (mem_rdata == OP_POP_PC || is_cond(mem_rdata, COND_RET_LOW))
                  begin
                     next_q.mem_addr = q.sp;
                     next_q.pop_hi = 1'b0;
                     next_q.st = ST_POP;
                     next_q.done = 1'b0;
                     next_q.mem_read = (mem_rdata == OP_POP_PC)
                                    || cond_true(mem_rdata[5:3], q.flags);
                     if (!next_q.mem_read)
                     begin
                        next_q.st = ST_FETCH;
                        next_q.done = 1'b1;
                     end
                  end
               end
            end
         end
         ST_OPERAND:
         begin
            if (mem_ready || is_cmp_reg)
            begin
               next_q.mem_read = 1'b0;
               next_q.flags = alu.flags_out;
               if (!is_cmp_reg && !is_cmp_mem)
               begin
                  next_q.acc = alu.result;
               end
               next_q.st = ST_FETCH;
               next_q.done = 1'b1;
            end
         end
         ST_ADDR_LO:
         begin
            if (mem_ready)
            begin
               next_q.addr_lo = mem_rdata;
               next_q.pc = pc_inc;
               next_q.mem_addr = pc_inc;
               next_q.st = ST_ADDR_HI;
               if ((is_cond(q.opcode, COND_JUMP_LOW) || is_cond(q.opcode, COND_CALL_LOW))
                   && !taken)
               begin
                  next_q.mem_read = 1'b0;
                  next_q.pc = pc_inc + 16'h0001;
                  next_q.st = ST_FETCH;
                  next_q.done = 1'b1;
               end
            end
         end
         ST_ADDR_HI:
         begin
            if (mem_ready)
            begin
               next_q.mem_read = 1'b0;
               next_q.pc = pc_inc;
               next_q.st = ST_FETCH;
               next_q.done = 1'b1;
               if (q.opcode == OP_JUMP_ABSOLUTE || (is_cond(q.opcode, COND_JUMP_LOW) && taken))
               begin
                  next_q.pc = {mem_rdata, q.addr_lo};
               end
               else if (q.opcode == OP_CALL || (is_cond(q.opcode, COND_CALL_LOW) && taken))
               begin
                  next_q.mem_addr = sp_dec;
                  next_q.mem_wdata = pc_inc[15:8];
                  next_q.mem_write = 1'b1;
                  next_q.addr_lo = q.addr_lo;
                  next_q.opcode = mem_rdata;
                  next_q.st = ST_PUSH_HI;
                  next_q.done = 1'b0;
               end
            end
         end
         ST_PUSH_HI:
         begin
            if (mem_ready)
            begin
               next_q.mem_addr = q.sp - 16'h0002;
               next_q.mem_wdata = q.pc[7:0];
               next_q.st = ST_PUSH_LO;
            end
         end
         ST_PUSH_LO:
         begin
            if (mem_ready)
            begin
               next_q.mem_write = 1'b0;
               next_q.sp = q.sp - 16'h0002;
               next_q.pc = {q.opcode, q.addr_lo};
               next_q.st = ST_FETCH;
               next_q.done = 1'b1;
            end
         end
         ST_POP:
         begin
            if (mem_ready)
            begin
               if (!q.pop_hi)
               begin
                  next_q.addr_lo = mem_rdata;
                  next_q.mem_addr = q.sp + 16'h0001;
                  next_q.pop_hi = 1'b1;
               end
               else
               begin
                  next_q.mem_read = 1'b0;
                  next_q.pc = {mem_rdata, q.addr_lo};
                  next_q.sp = q.sp + 16'h0002;
                  next_q.st = ST_FETCH;
                  next_q.done = 1'b1;
               end
            end
         end
         default: next_q.st = ST_FETCH;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         q <= '{st: ST_FETCH, opcode: 8'h00, addr_lo: 8'h00, pop_hi: 1'b0,
                mem_addr: 16'h0000, mem_wdata: 8'h00, mem_read: 1'b0, mem_write: 1'b0,
                acc: ACC_RESET, flags: FLAGS_RESET, pc: PC_RESET, sp: SP_RESET,
                done: 1'b0};
      end
      else
      begin
         q <= next_q;
      end
   end

   assign mem_addr = q.mem_addr;
   assign mem_wdata = q.mem_wdata;
   assign mem_read = q.mem_read;
   assign mem_write = q.mem_write;
   assign accumulator = q.acc;
   assign flags = q.flags;
   assign program_counter = q.pc;
   assign stack_pointer = q.sp;
   assign instr_done = q.done;
endmodule : logic_rotate_branch_exec

/* File: tb/mem_model.sv */
// Purpose: Memory for program bytes and stack beside the executor.
// Assumes: A 256-byte image, addressed by the low address byte.
// Notes: Read data turns over every cycle while no answer is given.
`timescale 1ns/1ps
module mem_model (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   input  wire logic        mem_read,
   input  wire logic        mem_write,
   input  wire logic [3:0]  waits,
   output logic [7:0]       mem_rdata,
   output logic             mem_ready,
   output int               xfers
);
   logic [7:0] mem [256];
   logic [3:0] cnt;
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mem_ready <= 1'b0;
         mem_rdata <= 8'h00;
         cnt       <= 4'h0;
         xfers     <= 0;
      end
      else if ((mem_read || mem_write) && !mem_ready && cnt == waits)
      begin
         mem_ready <= 1'b1;
         cnt       <= 4'h0;
         xfers     <= xfers + 1;
         if (mem_read)
            mem_rdata <= mem[mem_addr[7:0]];
         else
            mem[mem_addr[7:0]] <= mem_wdata;
      end
      else
      begin
         mem_ready <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if ((mem_read || mem_write) && !mem_ready)
            cnt <= cnt + 4'h1;
      end
   end
endmodule : mem_model

/* File: tb/exec_assertions.sv */
// Purpose: Port-level checks on the executor.
// Assumes: One clock domain with an active-low asynchronous reset.
// Notes: Attached to every executor instance.
`timescale 1ns/1ps
module exec_assertions (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0]  mem_wdata,
   input wire logic        mem_read,
   input wire logic        mem_write,
   input wire logic        mem_ready,
   input wire logic [7:0]  accumulator,
   input wire logic [7:0]  flags,
   input wire logic [15:0] stack_pointer,
   input wire logic        instr_done
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence rd_wait;
      mem_read && !mem_ready;
   endsequence
   sequence wr_wait;
      mem_write && !mem_ready;
   endsequence
   sequence fetch_start;
      $rose(mem_read);
   endsequence
   property sp_by_two;
      $changed(stack_pointer) |-> stack_pointer == $past(stack_pointer) + 16'h0002
         || stack_pointer == $past(stack_pointer) - 16'h0002;
   endproperty
   read_hold_a: assert property (rd_wait |=> mem_read && $stable(mem_addr))
      else $error("read released early");
   write_hold_a: assert property (wr_wait |=> mem_write && $stable({mem_addr, mem_wdata}))
      else $error("write released early");
   one_strobe_a: assert property (!(mem_read && mem_write))
      else $error("read and write together");
   done_pulse_a: assert property (instr_done |=> !instr_done)
      else $error("done longer than one cycle");
   sp_step_a: assert property (sp_by_two)
      else $error("stack pointer moved by other than two");
   wait_freeze_a: assert property ((mem_read || mem_write) && !mem_ready
      |=> $stable({accumulator, flags, stack_pointer}))
      else $error("state moved during a wait");
   done_bound_a: assert property (fetch_start |-> ##[1:80] instr_done)
      else $error("instruction did not finish");
   idle_done_a: assert property (instr_done |-> !mem_read && !mem_write)
      else $error("transfer open at completion");
endmodule : exec_assertions

bind logic_rotate_branch_exec exec_assertions chk_u (.clk, .arst_n, .mem_addr, .mem_wdata,
   .mem_read, .mem_write, .mem_ready, .accumulator, .flags, .stack_pointer, .instr_done);

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the logic, rotate and branch executor.
// Assumes: Instructions are placed in the memory image just before each runs.
// Notes: Expected values are worked out from the opcode semantics.
`timescale 1ns/1ps
module tb_top;
   import exec_pkg::*;
   logic        clk, arst_n, run, mem_ready, mem_read, mem_write, instr_done;
   logic [15:0] ptr_pair, mem_addr, program_counter, stack_pointer, epc, tgt, ret;
   logic [7:0]  reg_operand, mem_rdata, mem_wdata, accumulator, flags, ef;
   logic [3:0]  waits;
   int          xfers, d, fails, samples_checked;
   logic_rotate_branch_exec dut_u (.clk, .arst_n, .run, .memory_pointer_pair(ptr_pair),
      .reg_operand, .mem_rdata, .mem_ready, .mem_addr, .mem_wdata, .mem_read, .mem_write,
      .accumulator, .flags, .program_counter, .stack_pointer, .instr_done);
   mem_model mem_u (.clk, .arst_n, .mem_addr, .mem_wdata, .mem_read, .mem_write, .waits,
      .mem_rdata, .mem_ready, .xfers);
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic taken(input logic [2:0] c, input logic [7:0] f);
      logic [3:0] sel = {f[SIGN_BIT], f[PARITY_BIT], f[CARRY_BIT], f[ZERO_BIT]};
      return sel[c[2:1]] == c[0];
   endfunction : taken
   task automatic step(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
      int i;
      int x0;
      mem_u.mem[epc[7:0]] = b0;
      mem_u.mem[8'(epc + 16'h0001)] = b1;
      mem_u.mem[8'(epc + 16'h0002)] = b2;
      x0 = xfers;
      run = 1'b1;
      i = 0;
      do
      begin
         @(posedge clk);
         #1;
         if (mem_read === 1'b1)
            run = 1'b0;
         i++;
      end while (i < 200 && instr_done !== 1'b1);
      d = xfers - x0;
      if (instr_done !== 1'b1)
      begin
         fails++;
         $display("Error at %0t: no completion", $time);
         summarize();
      end
   endtask : step
   task automatic t_logic();
      chk({accumulator, flags}, {ACC_RESET, FLAGS_RESET});
      chk(stack_pointer | program_counter, SP_RESET | PC_RESET);
      ptr_pair = 16'h00C0;
      mem_u.mem[8'hC0] = 8'h18;
      step(OP_FORCE_CARRY, 8'h00, 8'h00);
      epc = epc + 16'h0001;
      step(OP_OR_IMMEDIATE, 8'hA5, 8'h00);
      chk({accumulator, flags & 8'h15, 8'(d)}, 24'hA5_0402);
      epc = epc + 16'h0002;
      step(OP_OR_MEMORY, 8'h00, 8'h00);
      chk({accumulator, flags & 8'h15, 8'(d)}, 24'hBD_0402);
      epc = epc + 16'h0001;
      step(OP_CMP_IMMEDIATE, 8'hBD, 8'h00);
      chk({accumulator, flags & 8'h41, 8'(d)}, 24'hBD_4002);
      epc = epc + 16'h0002;
      mem_u.mem[8'hC0] = 8'hC0;
      step(OP_CMP_MEMORY, 8'h00, 8'h00);
      chk({accumulator, flags & 8'h41, 8'(d)}, 24'hBD_0102);
      reg_operand = 8'hBD;
      epc = epc + 16'h0001;
      step({OP_CMP_REG_TOP, 3'h0}, 8'h00, 8'h00);
      chk({accumulator, flags & 8'h41, 8'(d)}, 24'hBD_4001);
      epc = epc + 16'h0001;
      chk(program_counter, epc);
      $display("logic test finished");
   endtask : t_logic
   task automatic t_rotate();
      logic [7:0] ops [7] = '{OP_ROT_LEFT_CIRC, OP_ROT_RIGHT_CIRC, OP_ROT_LEFT_CARRY,
         OP_ROT_RIGHT_CARRY, OP_INVERT_ACC, OP_INVERT_CARRY, OP_FORCE_CARRY};
      logic [7:0] a = 8'hBD;
      logic [7:0] f0 = flags;
      logic [7:0] ea;
      logic       c = 1'b0;
      logic       ec;
      for (int k = 0; k < 7; k++)
      begin
         case (k)
            0: {ec, ea} = {a[7], a[6:0], a[7]};
            1: {ec, ea} = {a[0], a[0], a[7:1]};
            2: {ec, ea} = {a[7], a[6:0], c};
            3: {ec, ea} = {a[0], c, a[7:1]};
            4: {ec, ea} = {c, ~a};
            5: {ec, ea} = {~c, a};
            default: {ec, ea} = {1'b1, a};
         endcase
         step(ops[k], 8'h00, 8'h00);
         epc = epc + 16'h0001;
         chk({accumulator, flags}, {ea, f0[7:1], ec});
         chk(16'(d), 16'h0001);
         a = ea;
         c = ec;
      end
      $display("rotate test finished");
   endtask : t_rotate
   task automatic t_branch();
      waits = 4'h1;
      step(OP_JUMP_ABSOLUTE, 8'h40, 8'h00);
      epc = 16'h0040;
      chk({program_counter[7:0], 8'(d)}, 16'h4003);
      for (int s = 0; s < 2; s++)
      begin
         ef = (s == 0) ? 8'h44 : 8'h81;
         step(OP_CMP_IMMEDIATE, (s == 0) ? 8'h42 : 8'h44, 8'h00);
         epc = epc + 16'h0002;
         chk(16'(flags & 8'hC5), 16'(ef));
         for (int c = 0; c < 8; c++)
         begin
            tgt = (epc + 16'h0010) & 16'h007F;
            step({CLASS_TOP, 3'(c), COND_JUMP_LOW}, tgt[7:0], 8'h00);
            epc = taken(3'(c), ef) ? tgt : epc + 16'h0003;
            chk({program_counter, 8'(d)}, {epc, taken(3'(c), ef) ? 8'h03 : 8'h02});
            tgt = (epc + 16'h0010) & 16'h007F;
            ret = epc + 16'h0003;
            step({CLASS_TOP, 3'(c), COND_CALL_LOW}, tgt[7:0], 8'h00);
            chk(16'(flags & 8'hC5), 16'(ef));
            if (taken(3'(c), ef))
            begin
               chk({program_counter, stack_pointer, 8'(d)}, {tgt, 16'hFFFE, 8'h05});
               chk({mem_u.mem[8'hFF], mem_u.mem[8'hFE]}, ret);
               epc = tgt;
               step({CLASS_TOP, 3'(c ^ 1), COND_RET_LOW}, 8'h00, 8'h00);
               chk({program_counter, 8'(d)}, {epc + 16'h0001, 8'h01});
               epc = epc + 16'h0001;
               step({CLASS_TOP, 3'(c), COND_RET_LOW}, 8'h00, 8'h00);
               chk({program_counter, stack_pointer, 8'(d)}, {ret, 16'h0000, 8'h03});
            end
            else
               chk({program_counter, stack_pointer, 8'(d)}, {ret, 16'h0000, 8'h02});
            epc = ret;
         end
      end
      $display("branch test finished");
   endtask : t_branch
   task automatic t_call();
      waits = 4'h3;
      ret = epc + 16'h0003;
      step(OP_CALL, 8'h60, 8'h00);
      chk({program_counter, stack_pointer, 8'(d)}, {16'h0060, 16'hFFFE, 8'h05});
      chk({mem_u.mem[8'hFF], mem_u.mem[8'hFE]}, ret);
      epc = 16'h0060;
      step(OP_POP_PC, 8'h00, 8'h00);
      chk({program_counter, stack_pointer, 8'(d)}, {ret, 16'h0000, 8'h03});
      $display("call test finished");
   endtask : t_call
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      {arst_n, run, ptr_pair, reg_operand, waits, epc, tgt, ret, ef} = '0;
      fails = 0;
      samples_checked = 0;
      repeat (16) @(posedge clk);
      #1;
      arst_n = 1'b1;
      t_logic();
      t_rotate();
      t_branch();
      t_call();
      summarize();
   end
endmodule : tb_top
